// *** hdl/fcc_pkg.sv ***
// constants for the flash crc check host controller
// assumes a 20 mhz system clock and a word-wide (x16) flash bus
package fcc_pkg;

    // ----------------------------------------------------------------
    // apb register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_EXP_LO = 8'h08;
    localparam logic [7:0] OFF_EXP_HI = 8'h0c;
    localparam logic [7:0] OFF_START = 8'h10;
    localparam logic [7:0] OFF_STOP = 8'h14;
    localparam logic [7:0] OFF_INT_STAT = 8'h18;
    localparam logic [7:0] OFF_INT_MASK = 8'h1c;
    localparam logic [7:0] OFF_POLL = 8'h20;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CTRL_GO_BIT = 0;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_PASS_BIT = 1;
    localparam int ST_FAIL_BIT = 2;
    localparam int INT_DONE_BIT = 0;
    localparam int INT_FAIL_BIT = 1;
    localparam int CHECK_ERROR_FLAG_BIT = 5;
    localparam logic [1:0] INT_MASK_RST = 2'h0;

    // ----------------------------------------------------------------
    // command sequence words
    // ----------------------------------------------------------------
    localparam logic [15:0] UNLOCK1_ADDR = 16'h0555;
    localparam logic [15:0] UNLOCK1_DATA = 16'h00aa;
    localparam logic [15:0] UNLOCK2_ADDR = 16'h02aa;
    localparam logic [15:0] UNLOCK2_DATA = 16'h0055;
    localparam logic [15:0] EXT_FUNC_CMD = 16'h00eb;
    localparam logic [15:0] CRC_SUBOP = 16'h0027;
    localparam logic [15:0] RANGE_COUNT = 16'h000a;
    localparam logic [15:0] RANGE_OPTION = 16'hfffe;
    localparam logic [15:0] RESERVED_WORD = 16'h0000;
    localparam logic [15:0] CONFIRM_CMD = 16'h0029;
    localparam logic [4:0] SEQ_LAST = 5'h10;

    // ----------------------------------------------------------------
    // bus timing
    // ----------------------------------------------------------------
    localparam int CLK_NS = 50;
    localparam int T_WE_LOW_NS = 100;
    localparam int T_READ_NS = 150;
    localparam logic [3:0] WE_CYC = 4'((T_WE_LOW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] RD_CYC = 4'((T_READ_NS + CLK_NS - 1) / CLK_NS);

    typedef enum logic [2:0] {
        FCC_IDLE, FCC_LOAD, FCC_WSET, FCC_WLOW, FCC_WHIGH, FCC_RGAP, FCC_RLOW
    } fcc_state_t;

endpackage

// *** hdl/fcc_host.sv ***
// host controller that runs a range crc check on a parallel nor flash
// assumes a word-wide flash bus, an apb master for software, a ready/busy pin
// Overview of operation
// [RL1] device computes crc over array or range, compares, reports pass/fail
// [RL2] device crc is 64-bit with polynomial constant 0x42f0e1eba9ea3693
// [RL3] device feeds data lsb first from an all-zero crc start value
// [RL4] host writes aa at 555, 55 at 2aa, then eb and 27 at zero
// [RL5] host writes count 000a then option fffe at offset zero
// [RL6] host writes expected crc as four words at offsets 1 to 4
// [RL7] host writes start byte address low half at 5, high at 6
// [RL8] host writes zero at 7, stop address at 8 and 9, zero at 10
// [RL9] host confirms with 29 at zero, then polls reads until ready
// [RL10] device sets check error bit 5 when crc mismatches
// [RL11] device treats range addresses as bytes regardless of bus width
// [RL12] device does nothing when stop address is not above start
// [RL13] device returns busy polling status on reads while checking
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
module fcc_host #(
    parameter int AW = 26
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic irq_out,
    // flash pins
    output logic [AW-1:0] flash_addr_out,
    output logic [15:0] flash_dq_out,
    output logic flash_dq_oe_out,
    input wire logic [15:0] flash_dq_in,
    output logic flash_ce_n_out,
    output logic flash_oe_n_out,
    output logic flash_we_n_out,
    input wire logic flash_ready_busy_n_in
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    fcc_pkg::fcc_state_t state_reg, state_next;
    logic [4:0] idx_reg, idx_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [63:0] exp_reg, exp_next;
    logic [31:0] start_reg, start_next, stop_reg, stop_next;
    logic [1:0] stat_reg, stat_next, mask_reg, mask_next;
    logic busy_reg, busy_next, pass_reg, pass_next, fail_reg, fail_next;
    logic [15:0] poll_reg, poll_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next, pslverr_reg, pslverr_next, irq_reg, irq_next;
    logic [AW-1:0] addr_reg, addr_next;
    logic [15:0] dq_reg, dq_next;
    logic oe_en_reg, oe_en_next, ce_n_reg, ce_n_next;
    logic oe_n_reg, oe_n_next, we_n_reg, we_n_next;
    logic [15:0] seq_addr, seq_data;
    logic wr_acc, rd_setup, go, done_ev, fail_ev;
    logic [1:0] set_bits;

    // ----------------------------------------------------------------
    // command sequence table
    // ----------------------------------------------------------------
    always_comb begin
        seq_addr = 16'h0000;
        seq_data = fcc_pkg::RESERVED_WORD;
        case (idx_reg)
            5'h00: begin
                seq_addr = fcc_pkg::UNLOCK1_ADDR; // see [RL4]
                seq_data = fcc_pkg::UNLOCK1_DATA;
            end
            5'h01: begin
                seq_addr = fcc_pkg::UNLOCK2_ADDR; // see [RL4]
                seq_data = fcc_pkg::UNLOCK2_DATA;
            end
            5'h02: seq_data = fcc_pkg::EXT_FUNC_CMD; // see [RL4]
            5'h03: seq_data = fcc_pkg::CRC_SUBOP; // see [RL4]
            5'h04: seq_data = fcc_pkg::RANGE_COUNT; // see [RL5]
            5'h05: seq_data = fcc_pkg::RANGE_OPTION; // see [RL5]
            5'h06, 5'h07, 5'h08, 5'h09: begin
                // expected crc, least significant word first
                seq_addr = {11'h000, idx_reg - 5'h05}; // see [RL6]
                seq_data = exp_reg[16*(idx_reg-5'h06) +: 16];
            end
            5'h0a: {seq_addr, seq_data} = {16'h0005, start_reg[15:0]}; // see [RL7]
            5'h0b: {seq_addr, seq_data} = {16'h0006, start_reg[31:16]}; // see [RL7]
            5'h0c: seq_addr = 16'h0007; // see [RL8]
            5'h0d: {seq_addr, seq_data} = {16'h0008, stop_reg[15:0]}; // see [RL8]
            5'h0e: {seq_addr, seq_data} = {16'h0009, stop_reg[31:16]}; // see [RL8]
            5'h0f: seq_addr = 16'h000a; // see [RL8]
            5'h10: seq_data = fcc_pkg::CONFIRM_CMD; // see [RL9]
            default: seq_addr = 16'h0000;
        endcase
    end

    // ----------------------------------------------------------------
    // apb decode, registers and flash sequencer
    // ----------------------------------------------------------------
    always_comb begin
        wr_acc = psel_in && penable_in && pwrite_in;
        rd_setup = psel_in && !penable_in;
        go = wr_acc && paddr_in == fcc_pkg::OFF_CTRL && pwdata_in[fcc_pkg::CTRL_GO_BIT];
        state_next = state_reg;
        idx_next = idx_reg;
        cnt_next = cnt_reg;
        exp_next = exp_reg;
        start_next = start_reg;
        stop_next = stop_reg;
        mask_next = mask_reg;
        busy_next = busy_reg;
        pass_next = pass_reg;
        fail_next = fail_reg;
        poll_next = poll_reg;
        addr_next = addr_reg;
        dq_next = dq_reg;
        oe_en_next = oe_en_reg;
        ce_n_next = ce_n_reg;
        oe_n_next = oe_n_reg;
        we_n_next = we_n_reg;
        done_ev = 1'b0;
        fail_ev = 1'b0;
        // zero wait states: answer is prepared in the setup cycle
        pready_next = rd_setup;
        pslverr_next = 1'b0;
        prdata_next = 32'h0000_0000;
        if (rd_setup) begin
            if (paddr_in == fcc_pkg::OFF_CTRL) begin
                prdata_next = 32'h0000_0000;
            end else if (paddr_in == fcc_pkg::OFF_STATUS) begin
                prdata_next = {29'h0, fail_reg, pass_reg, busy_reg};
            end else if (paddr_in == fcc_pkg::OFF_EXP_LO) begin
                prdata_next = exp_reg[31:0];
            end else if (paddr_in == fcc_pkg::OFF_EXP_HI) begin
                prdata_next = exp_reg[63:32];
            end else if (paddr_in == fcc_pkg::OFF_START) begin
                prdata_next = start_reg;
            end else if (paddr_in == fcc_pkg::OFF_STOP) begin
                prdata_next = stop_reg;
            end else if (paddr_in == fcc_pkg::OFF_INT_STAT) begin
                prdata_next = {30'h0, stat_reg};
            end else if (paddr_in == fcc_pkg::OFF_INT_MASK) begin
                prdata_next = {30'h0, mask_reg};
            end else if (paddr_in == fcc_pkg::OFF_POLL) begin
                prdata_next = {16'h0, poll_reg};
            end else begin
                pslverr_next = 1'b1;
            end
        end
        // parameters are frozen while a check runs so the sequence stays coherent
        if (wr_acc && !busy_reg) begin
            if (paddr_in == fcc_pkg::OFF_EXP_LO) exp_next[31:0] = pwdata_in;
            else if (paddr_in == fcc_pkg::OFF_EXP_HI) exp_next[63:32] = pwdata_in;
            else if (paddr_in == fcc_pkg::OFF_START) start_next = pwdata_in;
            else if (paddr_in == fcc_pkg::OFF_STOP) stop_next = pwdata_in;
        end
        if (wr_acc && paddr_in == fcc_pkg::OFF_INT_MASK) mask_next = pwdata_in[1:0];
        case (state_reg)
            fcc_pkg::FCC_IDLE: begin
                if (go) begin
                    busy_next = 1'b1;
                    pass_next = 1'b0;
                    fail_next = 1'b0;
                    idx_next = 5'h00;
                    ce_n_next = 1'b0;
                    state_next = fcc_pkg::FCC_LOAD;
                end
            end
            fcc_pkg::FCC_LOAD: begin
                addr_next = AW'(seq_addr);
                dq_next = seq_data;
                oe_en_next = 1'b1;
                state_next = fcc_pkg::FCC_WSET;
            end
            fcc_pkg::FCC_WSET: begin
                we_n_next = 1'b0;
                cnt_next = 4'h1;
                state_next = fcc_pkg::FCC_WLOW;
            end
            fcc_pkg::FCC_WLOW: begin
                cnt_next = cnt_reg + 4'h1;
                if (cnt_reg == fcc_pkg::WE_CYC) begin
                    we_n_next = 1'b1;
                    state_next = fcc_pkg::FCC_WHIGH;
                end
            end
            fcc_pkg::FCC_WHIGH: begin
                if (idx_reg == fcc_pkg::SEQ_LAST) begin
                    oe_en_next = 1'b0;
                    addr_next = '0;
                    state_next = fcc_pkg::FCC_RGAP; // see [RL9]
                end else begin
                    idx_next = idx_reg + 5'h01;
                    state_next = fcc_pkg::FCC_LOAD;
                end
            end
            fcc_pkg::FCC_RGAP: begin
                oe_n_next = 1'b0;
                cnt_next = 4'h1;
                state_next = fcc_pkg::FCC_RLOW;
            end
            fcc_pkg::FCC_RLOW: begin
                cnt_next = cnt_reg + 4'h1;
                if (cnt_reg == fcc_pkg::RD_CYC) begin
                    oe_n_next = 1'b1;
                    poll_next = flash_dq_in;
                    // keep polling until the ready pin reports completion
                    if (flash_ready_busy_n_in) begin
                        ce_n_next = 1'b1;
                        busy_next = 1'b0;
                        fail_ev = flash_dq_in[fcc_pkg::CHECK_ERROR_FLAG_BIT];
                        fail_next = fail_ev;
                        pass_next = !fail_ev;
                        done_ev = 1'b1;
                        state_next = fcc_pkg::FCC_IDLE;
                    end else begin
                        state_next = fcc_pkg::FCC_RGAP; // see [RL9]
                    end
                end
            end
            default: state_next = fcc_pkg::FCC_IDLE;
        endcase
        // event wins over a simultaneous write-one-to-clear
        set_bits = 2'b00;
        set_bits[fcc_pkg::INT_DONE_BIT] = done_ev;
        set_bits[fcc_pkg::INT_FAIL_BIT] = fail_ev;
        stat_next = stat_reg;
        if (wr_acc && paddr_in == fcc_pkg::OFF_INT_STAT) begin
            stat_next = stat_reg & ~pwdata_in[1:0];
        end
        stat_next = stat_next | set_bits;
        irq_next = |(stat_next & mask_next);
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_reg <= fcc_pkg::FCC_IDLE;
            idx_reg <= 5'h00;
            cnt_reg <= 4'h0;
            exp_reg <= 64'h0;
            start_reg <= 32'h0;
            stop_reg <= 32'h0;
            stat_reg <= 2'h0;
            mask_reg <= fcc_pkg::INT_MASK_RST;
            busy_reg <= 1'b0;
            pass_reg <= 1'b0;
            fail_reg <= 1'b0;
            poll_reg <= 16'h0;
            prdata_reg <= 32'h0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            irq_reg <= 1'b0;
            addr_reg <= '0;
            dq_reg <= 16'h0;
            oe_en_reg <= 1'b0;
            ce_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            idx_reg <= idx_next;
            cnt_reg <= cnt_next;
            exp_reg <= exp_next;
            start_reg <= start_next;
            stop_reg <= stop_next;
            stat_reg <= stat_next;
            mask_reg <= mask_next;
            busy_reg <= busy_next;
            pass_reg <= pass_next;
            fail_reg <= fail_next;
            poll_reg <= poll_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            irq_reg <= irq_next;
            addr_reg <= addr_next;
            dq_reg <= dq_next;
            oe_en_reg <= oe_en_next;
            ce_n_reg <= ce_n_next;
            oe_n_reg <= oe_n_next;
            we_n_reg <= we_n_next;
        end
    end

    assign prdata_out = prdata_reg;
    assign pready_out = pready_reg;
    assign pslverr_out = pslverr_reg;
    assign irq_out = irq_reg;
    assign flash_addr_out = addr_reg;
    assign flash_dq_out = dq_reg;
    assign flash_dq_oe_out = oe_en_reg;
    assign flash_ce_n_out = ce_n_reg;
    assign flash_oe_n_out = oe_n_reg;
    assign flash_we_n_out = we_n_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    sequence confirm_write_s;
        !we_n_reg && idx_reg == fcc_pkg::SEQ_LAST ##1 we_n_reg;
    endsequence

    chk_unlock_words: assert property ( // see [RL4]
        $fell(we_n_reg) && idx_reg < 5'h02 |-> !ce_n_reg && oe_en_reg
            && flash_dq_out == (idx_reg == 5'h00 ? fcc_pkg::UNLOCK1_DATA : fcc_pkg::UNLOCK2_DATA)
            && flash_addr_out[15:0] == (idx_reg == 5'h00 ? fcc_pkg::UNLOCK1_ADDR
                                        : fcc_pkg::UNLOCK2_ADDR))
        else $error("unlock write wrong");
    chk_count_option: assert property ( // see [RL5]
        !we_n_reg && idx_reg == 5'h05 |-> flash_dq_out == fcc_pkg::RANGE_OPTION
            && $past(flash_dq_out, 6) == fcc_pkg::RANGE_COUNT && flash_addr_out == '0)
        else $error("count or option word wrong");
    chk_crc_words: assert property ( // see [RL6]
        !we_n_reg && idx_reg == 5'h06 |-> flash_addr_out == AW'(1)
            && flash_dq_out == exp_reg[15:0])
        else $error("expected crc word wrong");
    chk_start_addr: assert property ( // see [RL7]
        !we_n_reg && idx_reg == 5'h0b |-> flash_addr_out == AW'(6)
            && flash_dq_out == start_reg[31:16])
        else $error("start address word wrong");
    chk_reserved_zero: assert property ( // see [RL8]
        !we_n_reg && (idx_reg == 5'h0c || idx_reg == 5'h0f) |-> flash_dq_out == 16'h0000)
        else $error("reserved word not zero");
    chk_confirm_poll: assert property ( // see [RL9]
        confirm_write_s |-> ##[1:3] !oe_n_reg && !flash_dq_oe_out)
        else $error("no poll read after confirm");
    chk_we_width: assert property ( // see [RL9]
        $fell(we_n_reg) |-> !we_n_reg [*2] ##1 we_n_reg && !ce_n_reg)
        else $error("write strobe width wrong");

endmodule

// *** sim/fcc_flash_model.sv ***
// behavioural flash with the range crc check command, driven by bus strobes
// assumes word-wide bus; words are latched on the rising edge of we_n
`timescale 1ns/1ps
module fcc_flash_model (
    // flash pins
    input wire logic [25:0] addr_in,
    input wire logic [15:0] dq_in,
    output logic [15:0] dq_out,
    input wire logic ce_n_in,
    input wire logic oe_n_in,
    input wire logic we_n_in,
    output logic ready_busy_n_out,
    // bench control and counters
    input wire logic slow_in,
    output int seq_err_out,
    output int crc_runs_out
);
    // ----------------------------------------------------------------
    // command sequence and check
    // ----------------------------------------------------------------
    localparam logic [63:0] POLY = 64'h42f0e1eba9ea3693;
    logic [15:0] w [0:16];
    logic [4:0] idx = 5'h0;
    logic fail = 1'b0;
    logic [31:0] st;
    logic [31:0] sp;
    initial ready_busy_n_out = 1'b1;
    initial seq_err_out = 0;
    initial crc_runs_out = 0;

    function automatic logic [7:0] mem_byte(input logic [31:0] a);
        return 8'(a * 32'h1d + 32'h07);
    endfunction

    // byte granular range, inclusive of the stop byte
    function automatic logic [63:0] crc_range(input logic [31:0] s, input logic [31:0] e);
        logic [63:0] c;
        logic [7:0] b;
        logic fb;
        c = 64'h0;
        for (logic [32:0] a = {1'b0, s}; a <= {1'b0, e}; a++) begin
            b = mem_byte(a[31:0]);
            for (int i = 0; i < 8; i++) begin
                fb = c[63] ^ b[i];
                c = {c[62:0], 1'b0};
                if (fb) c = c ^ POLY;
            end
        end
        return c;
    endfunction

    // reads give polling status; bit 5 low while busy
    // undriven bus shows the inverse so a stale value never passes
    assign dq_out = (!ce_n_in && !oe_n_in) ? {10'h0, fail, 5'h0} : ~{10'h0, fail, 5'h0};

    always @(posedge we_n_in) begin
        if (!ce_n_in) begin
            w[idx] = dq_in;
            // address of each command word, data of the fixed command words only
            if (addr_in !== ((idx == 0) ? 26'h555 : (idx == 1) ? 26'h2aa :
                    (idx <= 5 || idx == 16) ? 26'h0 : 26'(idx - 5))) seq_err_out++;
            case (idx)
                0: if (dq_in !== 16'h00aa) seq_err_out++;
                1: if (dq_in !== 16'h0055) seq_err_out++;
                2: if (dq_in !== 16'h00eb) seq_err_out++;
                3: if (dq_in !== 16'h0027) seq_err_out++;
                4: if (dq_in !== 16'h000a) seq_err_out++;
                5: if (dq_in !== 16'hfffe) seq_err_out++;
                12, 15: if (dq_in !== 16'h0000) seq_err_out++;
                16: if (dq_in !== 16'h0029) seq_err_out++;
                default: ;
            endcase
            if (idx == 16) begin
                idx = 5'h0;
                fail = 1'b0;
                st = {w[11], w[10]};
                sp = {w[14], w[13]};
                // no action unless stop is above start
                if (sp > st) begin
                    crc_runs_out++;
                    ready_busy_n_out = 1'b0;
                    // off the clock edge so ready and status never race the host's sampling
                    #(slow_in ? 2010 : 210);
                    fail = crc_range(st, sp) != {w[9], w[8], w[7], w[6]};
                    ready_busy_n_out = 1'b1;
                end
            end else begin
                idx = idx + 5'h1;
            end
        end
    end
endmodule

// *** sim/fcc_host_tb.sv ***
// self-checking bench for the crc check host controller
// assumes the flash model above on the flash pins and apb from the bench
`timescale 1ns/1ps
module fcc_host_tb;
    // ----------------------------------------------------------------
    // signals, design and partner
    // ----------------------------------------------------------------
    logic clk_in = 1'b0, nrst_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0;
    logic pwrite_in = 1'b0, slow = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0, prdata_out, q;
    logic pready_out, pslverr_out, irq_out, dq_oe, ce_n, oe_n, we_n, rb_n, bad, e_bit;
    logic [25:0] faddr;
    logic [15:0] host_dq, mod_dq, bus_dq;
    logic [63:0] e;
    logic [31:0] st, sp;
    logic [1:0] mask;
    logic xf;
    int fails = 0, checks_done = 0, runs0, k, seq_err, crc_runs;

    assign bus_dq = dq_oe ? host_dq : mod_dq;
    initial forever #25 clk_in = ~clk_in;

    fcc_host u_fcc_host (.clk_in(clk_in), .nrst_in(nrst_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .irq_out(irq_out), .flash_addr_out(faddr),
        .flash_dq_out(host_dq), .flash_dq_oe_out(dq_oe), .flash_dq_in(bus_dq),
        .flash_ce_n_out(ce_n), .flash_oe_n_out(oe_n), .flash_we_n_out(we_n),
        .flash_ready_busy_n_in(rb_n));

    fcc_flash_model u_fcc_flash_model (.addr_in(faddr), .dq_in(bus_dq), .dq_out(mod_dq),
        .ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n), .ready_busy_n_out(rb_n),
        .slow_in(slow), .seq_err_out(seq_err), .crc_runs_out(crc_runs));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // setup, then access held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 16);
        if (n >= 16) fails++;
        q = prdata_out;
        e_bit = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        #3_000_000;
        fails++;
        results();
    end

    initial begin
        repeat (8) @(posedge clk_in);
        nrst_in <= 1'b1;
        k = $urandom(87931);
        apb(1'b0, fcc_pkg::OFF_INT_MASK, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, 8'h24, 32'h0);
        chk({q[30:0], e_bit}, 32'h1);
        $display("test reset done");
        for (int n = 0; n < 8; n++) begin
            st = $urandom_range(1, 40);
            // equal and reversed ends first, then real ranges
            sp = (n == 0) ? st : (n == 1) ? st - 1 : st + $urandom_range(1, 24);
            bad = $urandom_range(0, 1);
            slow <= 1'($urandom_range(0, 1));
            mask = 2'($urandom_range(0, 3));
            e = u_fcc_flash_model.crc_range(st, sp) ^ {63'h0, bad};
            xf = (sp > st) && bad;
            apb(1'b1, fcc_pkg::OFF_INT_MASK, {30'h0, mask});
            apb(1'b1, fcc_pkg::OFF_EXP_LO, e[31:0]);
            apb(1'b1, fcc_pkg::OFF_EXP_HI, e[63:32]);
            apb(1'b1, fcc_pkg::OFF_START, st);
            apb(1'b1, fcc_pkg::OFF_STOP, sp);
            runs0 = crc_runs;
            apb(1'b1, fcc_pkg::OFF_CTRL, 32'h1);
            apb(1'b0, fcc_pkg::OFF_STATUS, 32'h0);
            chk(q[0], 32'h1);
            // parameters must stay frozen while the command runs
            apb(1'b1, fcc_pkg::OFF_START, ~st);
            apb(1'b0, fcc_pkg::OFF_START, 32'h0);
            chk(q, st);
            k = 0;
            do begin
                apb(1'b0, fcc_pkg::OFF_STATUS, 32'h0);
                k++;
            end while (q[0] !== 1'b0 && k < 400);
            chk(32'(k < 400), 32'h1);
            chk(q[2:0], {29'h0, xf, ~xf, 1'b0});
            apb(1'b0, fcc_pkg::OFF_POLL, 32'h0);
            chk(q[5], 32'(xf));
            chk(32'(crc_runs - runs0), 32'(sp > st));
            chk(32'(seq_err), 32'h0);
            apb(1'b0, fcc_pkg::OFF_INT_STAT, 32'h0);
            chk(q[1:0], {30'h0, xf, 1'b1});
            chk(irq_out, 32'(|({xf, 1'b1} & mask)));
            apb(1'b1, fcc_pkg::OFF_INT_STAT, 32'h3);
            @(posedge clk_in);
            @(posedge clk_in);
            chk({irq_out, ce_n}, 32'h1);
            $display("test range %0d done", n);
        end
        results();
    end
endmodule
